// [src/sram_ctrl_map.svh]
// Purpose: Pin timing figures and field positions of the static memory port.
// Assumes: A 25 MHz controller clock; all figures in ps unless named _us or _MHZ.
// Notes:   Cycle counts round every least time up to whole clock cycles.
//
// Function
// R1 - Deselected memory ignores controls, floats, idles.
// R2 - Low-lane-only read drives bits 0 to 7.
// R3 - High-lane-only read drives bits 8 to 15.
// R4 - Read needs select, drive low, strobe high.
// R5 - Low-lane-only write keeps upper byte.
// R6 - High-lane-only write keeps lower byte.
// R7 - Write needs select, strobe, one lane low.
// R8 - Any control rising ends the internal write.
// R9 - Write data steady 5.5 ns before end.
// R10 - Disabled lanes or drive high float outputs.
// R11 - Select and strobe rising together stay floating.
// R12 - Wait 100 us after power before access.
// R13 - Read data valid 10 ns after address.
// R14 - Data valid 5 ns after drive or lane.
// R15 - Write cycle at least 10 ns long.
// R16 - Address setup 7 ns, strobe low 7 ns.
// R17 - Release data bus before asserting read drive.
`ifndef SRAM_CTRL_MAP_SVH
`define SRAM_CTRL_MAP_SVH

// =====================================================================
// Clock and timing figures
`define SRAM_CLK_PS      40000
`define SRAM_CLK_MHZ     25
`define SRAM_T_POWER_US  100
`define SRAM_T_AA_PS     10000
`define SRAM_T_DOE_PS    5000
`define SRAM_T_HZ_PS     5000
`define SRAM_T_RC_PS     10000
`define SRAM_T_WC_PS     10000
`define SRAM_T_PWE_PS    7000
`define SRAM_T_AW_PS     7000
`define SRAM_T_SD_PS     5500

// =====================================================================
// Derived cycle counts, rounded up, never below one
`define SRAM_CEIL(ps) (((ps) + `SRAM_CLK_PS - 1) / `SRAM_CLK_PS)
`define SRAM_POWER_CYC (`SRAM_T_POWER_US * `SRAM_CLK_MHZ)
`define SRAM_PWE_CYC   `SRAM_CEIL(`SRAM_T_PWE_PS)
`define SRAM_RD_CYC    `SRAM_CEIL(`SRAM_T_AA_PS)
`define SRAM_HZ_CYC    `SRAM_CEIL(`SRAM_T_HZ_PS)

// =====================================================================
// Widths and field positions
`define SRAM_ADDR_W    20
`define SRAM_DATA_W    16
`define SRAM_LANE_LO   0
`define SRAM_LANE_HI   1
`define SRAM_BYTE_LO   7:0
`define SRAM_BYTE_HI   15:8
`define SRAM_PWR_W     12
`define SRAM_PH_W      4
`define SRAM_LANES_OFF 2'h3
`define SRAM_LANES_ALL 2'h0

`endif

// [src/sram_ctrl_pkg.sv]
// Purpose: Types shared by the static memory controller.
// Assumes: Nothing beyond the map header.
// Notes:   Only types live here; figures live in the map header.
package sram_ctrl_pkg;

	// =================================================================
	// Controller states
	typedef enum logic [2:0] {
		ST_POWER,
		ST_IDLE,
		ST_WR_SETUP,
		ST_WR_PULSE,
		ST_WR_HOLD,
		ST_RD_ACCESS,
		ST_RD_END
	} ctrl_state_t;

endpackage : sram_ctrl_pkg

// [src/cycle_timer.sv]
// Purpose: Down counter that measures a number of clock cycles.
// Assumes: Load has priority over counting.
// Notes:   Done is high while the count stands at zero.
module cycle_timer #(
	parameter int             W         = 4,
	parameter logic [W-1:0]   RESET_VAL = '0
) (
	input  wire logic         i_clk,
	input  wire logic         i_arst_n,
	input  wire logic         i_load,
	input  wire logic [W-1:0] i_value,
	output logic              o_done
);

	logic [W-1:0] count_r;

	// =================================================================
	// Counter
	// Counting stops at zero so a forgotten load never wraps around.
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			count_r <= RESET_VAL;
		end else if (i_load) begin
			count_r <= i_value;
		end else if (count_r != '0) begin
			count_r <= count_r - W'(1);
		end
	end

	assign o_done = (count_r == '0);

endmodule : cycle_timer

// [src/sram_ctrl.sv]
// Purpose: Host controller for an asynchronous 1M x 16 static memory.
// Assumes: A 25 MHz clock; memory pins registered; data bus split by
//          output enable, which is low while this end drives the bus.
// Notes:   One request at a time; read data returns as a one-cycle pulse.
`include "sram_ctrl_map.svh"

module sram_ctrl (
	input  wire logic                      i_clk,
	input  wire logic                      i_arst_n,
	// User request side.
	input  wire logic                      i_req_valid,
	output logic                           o_req_ready,
	input  wire logic                      i_req_write,
	input  wire logic [`SRAM_ADDR_W-1:0]   i_req_addr,
	input  wire logic [`SRAM_DATA_W-1:0]   i_req_wdata,
	input  wire logic [1:0]                i_req_be,
	output logic                           o_rsp_valid,
	output logic [`SRAM_DATA_W-1:0]        o_rsp_rdata,
	output logic                           o_init_done,
	// Memory pins.
	output logic [`SRAM_ADDR_W-1:0]        o_sram_addr,
	output logic                           o_chip_sel_n,
	output logic                           o_out_drive_n,
	output logic                           o_write_strobe_n,
	output logic                           o_low_lane_enable_n,
	output logic                           o_high_lane_enable_n,
	input  wire logic [`SRAM_DATA_W-1:0]   i_sram_data,
	output logic [`SRAM_DATA_W-1:0]        o_sram_data,
	output logic                           o_sram_data_oe_n
);

	sram_ctrl_pkg::ctrl_state_t state_r;
	sram_ctrl_pkg::ctrl_state_t state_nxt;
	logic                       power_done;
	logic                       phase_done;
	logic                       phase_load;
	logic [`SRAM_PH_W-1:0]      phase_value;
	logic [1:0]                 lanes_n_nxt;
	logic                       req_take;

	// =================================================================
	// Power-up wait
	// No access is accepted until the supply has settled for the full
	// wait; the count restarts with every reset.
	cycle_timer #(
		.W         (`SRAM_PWR_W),
		.RESET_VAL (`SRAM_PWR_W'(`SRAM_POWER_CYC))
	) u_power_timer (
		.i_clk    (i_clk),
		.i_arst_n (i_arst_n),
		.i_load   (1'b0),
		.i_value  ('0),
		.o_done   (power_done)
	);

	// =================================================================
	// Phase timer
	// Measures the strobe pulse, the read access and the bus float time.
	cycle_timer #(
		.W         (`SRAM_PH_W),
		.RESET_VAL ('0)
	) u_phase_timer (
		.i_clk    (i_clk),
		.i_arst_n (i_arst_n),
		.i_load   (phase_load),
		.i_value  (phase_value),
		.o_done   (phase_done)
	);

	// =================================================================
	// Request handshake
	// Requests are taken only from idle, a state in which the data bus
	// is always released.
	assign o_req_ready = (state_r == sram_ctrl_pkg::ST_IDLE);
	assign req_take    = o_req_ready && i_req_valid;
	assign o_init_done = (state_r != sram_ctrl_pkg::ST_POWER);

	// =================================================================
	// Next state
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			sram_ctrl_pkg::ST_POWER: begin
				if (power_done) begin
					state_nxt = sram_ctrl_pkg::ST_IDLE; // R12
				end
			end
			sram_ctrl_pkg::ST_IDLE: begin
				if (req_take && i_req_write) begin
					state_nxt = sram_ctrl_pkg::ST_WR_SETUP;
				end else if (req_take) begin
					state_nxt = sram_ctrl_pkg::ST_RD_ACCESS;
				end
			end
			sram_ctrl_pkg::ST_WR_SETUP: begin
				state_nxt = sram_ctrl_pkg::ST_WR_PULSE;
			end
			sram_ctrl_pkg::ST_WR_PULSE: begin
				if (phase_done) begin
					state_nxt = sram_ctrl_pkg::ST_WR_HOLD;
				end
			end
			sram_ctrl_pkg::ST_WR_HOLD: begin
				state_nxt = sram_ctrl_pkg::ST_IDLE;
			end
			sram_ctrl_pkg::ST_RD_ACCESS: begin
				if (phase_done) begin
					state_nxt = sram_ctrl_pkg::ST_RD_END;
				end
			end
			sram_ctrl_pkg::ST_RD_END: begin
				if (phase_done) begin
					state_nxt = sram_ctrl_pkg::ST_IDLE;
				end
			end
			default: begin
				state_nxt = sram_ctrl_pkg::ST_POWER;
			end
		endcase
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state_r <= sram_ctrl_pkg::ST_POWER;
		end else begin
			state_r <= state_nxt;
		end
	end

	// =================================================================
	// Phase timer loading
	// Each timed state is loaded one short of its length, so a count of
	// one cycle leaves the state on the next edge.
	always_comb begin
		phase_load  = 1'b0;
		phase_value = '0;
		if (state_r == sram_ctrl_pkg::ST_WR_SETUP) begin
			phase_load  = 1'b1;
			phase_value = `SRAM_PH_W'(`SRAM_PWE_CYC - 1); // R16
		end else if (req_take && !i_req_write) begin
			phase_load  = 1'b1;
			phase_value = `SRAM_PH_W'(`SRAM_RD_CYC - 1); // R13
		end else if (state_r == sram_ctrl_pkg::ST_RD_ACCESS
				&& phase_done) begin
			phase_load  = 1'b1;
			phase_value = `SRAM_PH_W'(`SRAM_HZ_CYC - 1); // R14
		end
	end

	// =================================================================
	// Lane enables
	// An empty byte mask means both lanes, so a write is never issued
	// with no lane low, which the memory would ignore.
	always_comb begin
		lanes_n_nxt = ~i_req_be;
		if (i_req_be == 2'h0) begin
			lanes_n_nxt = `SRAM_LANES_ALL; // R7
		end
	end

	// =================================================================
	// Address and lane registers
	// Both are held from setup until the cycle after the strobe rises,
	// which gives the zero hold times a full cycle of margin.
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_sram_addr          <= '0;
			o_low_lane_enable_n  <= 1'b1;
			o_high_lane_enable_n <= 1'b1;
		end else if (req_take) begin
			o_sram_addr          <= i_req_addr; // R16
			o_low_lane_enable_n  <= lanes_n_nxt[`SRAM_LANE_LO]; // R2
			o_high_lane_enable_n <= lanes_n_nxt[`SRAM_LANE_HI]; // R3
		end else if (state_nxt == sram_ctrl_pkg::ST_IDLE) begin
			o_low_lane_enable_n  <= 1'b1;
			o_high_lane_enable_n <= 1'b1;
		end
	end

	// =================================================================
	// Control strobes
	// Select covers setup, pulse and hold of a write so the strobe alone
	// ends it; select and strobe never rise on the same edge.
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_chip_sel_n     <= 1'b1;
			o_write_strobe_n <= 1'b1;
			o_out_drive_n    <= 1'b1;
		end else begin
			o_chip_sel_n     <= !(state_nxt == sram_ctrl_pkg::ST_WR_SETUP
				|| state_nxt == sram_ctrl_pkg::ST_WR_PULSE
				|| state_nxt == sram_ctrl_pkg::ST_WR_HOLD
				|| state_nxt == sram_ctrl_pkg::ST_RD_ACCESS); // R1
			o_write_strobe_n <=
				!(state_nxt == sram_ctrl_pkg::ST_WR_PULSE); // R7 R8 R11
			o_out_drive_n    <=
				!(state_nxt == sram_ctrl_pkg::ST_RD_ACCESS); // R4 R17
		end
	end

	// =================================================================
	// Write data drive
	// Data is driven from setup through hold, so it is steady a whole
	// cycle before and after the strobe edge that ends the write.
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_sram_data <= '0;
		end else if (req_take && i_req_write) begin
			o_sram_data <= i_req_wdata; // R9
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_sram_data_oe_n <= 1'b1;
		end else begin
			o_sram_data_oe_n <= !(state_nxt == sram_ctrl_pkg::ST_WR_SETUP
				|| state_nxt == sram_ctrl_pkg::ST_WR_PULSE
				|| state_nxt == sram_ctrl_pkg::ST_WR_HOLD); // R17 R15
		end
	end

	// =================================================================
	// Read capture
	// Data is sampled on the edge that ends the access, while select and
	// drive are still low, so it is never taken from a floating bus.
	// Lanes that were not enabled return zero rather than bus noise.
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_rsp_valid <= 1'b0;
			o_rsp_rdata <= '0;
		end else if (state_r == sram_ctrl_pkg::ST_RD_ACCESS
				&& phase_done) begin
			o_rsp_valid      <= 1'b1; // R13
			o_rsp_rdata[`SRAM_BYTE_LO] <= o_low_lane_enable_n ?
				8'h00 : i_sram_data[`SRAM_BYTE_LO]; // R2 R10
			o_rsp_rdata[`SRAM_BYTE_HI] <= o_high_lane_enable_n ?
				8'h00 : i_sram_data[`SRAM_BYTE_HI]; // R3 R10
		end else begin
			o_rsp_valid <= 1'b0;
		end
	end

endmodule : sram_ctrl

// [testbench/sram_ctrl_monitor.sv]
// Purpose: Pin order checks on the static memory controller.
// Assumes: Bound to sram_ctrl; one clock domain.
// Notes:   Only controller outputs are judged.
`include "sram_ctrl_map.svh"
module sram_ctrl_monitor (
	input wire logic        i_clk,
	input wire logic        i_arst_n,
	input wire logic        i_req_valid,
	input wire logic        i_req_write,
	input wire logic        o_req_ready,
	input wire logic        o_rsp_valid,
	input wire logic        o_chip_sel_n,
	input wire logic        o_out_drive_n,
	input wire logic        o_write_strobe_n,
	input wire logic        o_low_lane_enable_n,
	input wire logic        o_high_lane_enable_n,
	input wire logic        o_sram_data_oe_n,
	input wire logic [15:0] o_sram_data,
	input wire logic [19:0] o_sram_addr
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int PWR = `SRAM_POWER_CYC;
	int pwr_cnt_r;
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);

	// =================================================================
	// Saturating count of cycles since reset, so an early select shows.
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n)
			pwr_cnt_r <= 0;
		else if (pwr_cnt_r < PWR)
			pwr_cnt_r <= pwr_cnt_r + 1;
	end

	// =================================================================
	// Assertions
	chk_power_wait: assert property (!o_chip_sel_n |-> pwr_cnt_r >= PWR)
		else $error("select before power wait");
	chk_read_strobe: assert property ((!o_out_drive_n && !o_chip_sel_n)
		|-> o_write_strobe_n) else $error("strobe low in read");
	chk_write_lanes: assert property (!o_write_strobe_n |-> !o_chip_sel_n
		&& !(o_low_lane_enable_n && o_high_lane_enable_n))
		else $error("write without select or lane");
	chk_data_steady: assert property ($rose(o_write_strobe_n)
		|-> !o_sram_data_oe_n && $stable(o_sram_data) && $stable(o_sram_addr)
		##1 ($stable(o_sram_data) && $stable(o_sram_addr)))
		else $error("data or address moved at write end");
	chk_select_apart: assert property ($rose(o_write_strobe_n)
		|-> !o_chip_sel_n) else $error("select rose with strobe");
	chk_strobe_setup: assert property ($fell(o_write_strobe_n)
		|-> !$past(o_chip_sel_n) && $stable(o_sram_addr))
		else $error("strobe fell without setup");
	chk_no_fight: assert property (!o_out_drive_n |-> o_sram_data_oe_n)
		else $error("bus driven during read");
	chk_float_first: assert property ($fell(o_out_drive_n)
		|-> $past(o_sram_data_oe_n)) else $error("no float before read");
	chk_read_answer: assert property ((i_req_valid && o_req_ready
		&& !i_req_write) |-> ##2 o_rsp_valid) else $error("read answer late");
	cover property ($rose(o_write_strobe_n) && o_high_lane_enable_n);
	cover property ($rose(o_write_strobe_n) && o_low_lane_enable_n);
	cover property (o_rsp_valid);
endmodule : sram_ctrl_monitor

// [testbench/sram_model.sv]
// Purpose: Behavioural 1M x 16 static memory with byte lanes.
// Assumes: Pins driven by the controller; no clock.
// Notes:   A floating lane shows the inverse of its last driven value.
module sram_model #(
	parameter int T_ACC = 8
) (
	input  wire logic [19:0] i_addr,
	input  wire logic        i_cs_n,
	input  wire logic        i_oe_n,
	input  wire logic        i_we_n,
	input  wire logic        i_lo_n,
	input  wire logic        i_hi_n,
	input  wire logic [15:0] i_bus,
	output logic      [15:0] o_data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] mem [int];
	logic [15:0] last_r = 16'h0000;
	logic [15:0] rd, raw, cur;
	logic [1:0]  lanes_r = 2'h3;
	logic        rd_on, wr_on, drv_lo, drv_hi;

	// =================================================================
	// Deselect, drive high or a write floats the bus.
	assign rd_on = !i_cs_n && !i_oe_n && i_we_n;
	assign wr_on = !i_cs_n && !i_we_n && !(i_lo_n && i_hi_n);
	always @* if (wr_on) lanes_r = {i_hi_n, i_lo_n};

	// =================================================================
	// Any control rising ends the write; only enabled lanes store.
	always @(negedge wr_on) begin
		cur = mem.exists(int'(i_addr)) ? mem[int'(i_addr)] : 16'h0000;
		if (!lanes_r[0]) cur[7:0] = i_bus[7:0];
		if (!lanes_r[1]) cur[15:8] = i_bus[15:8];
		if (lanes_r != 2'h3) mem[int'(i_addr)] = cur;
	end

	// =================================================================
	// Each enabled lane drives after the access delay.
	always @* begin
		rd = mem.exists(int'(i_addr)) ? mem[int'(i_addr)] : ~i_addr[15:0];
		drv_lo = rd_on && !i_lo_n;
		drv_hi = rd_on && !i_hi_n;
		if (drv_lo) last_r[7:0] = rd[7:0];
		if (drv_hi) last_r[15:8] = rd[15:8];
		raw = {drv_hi ? rd[15:8] : ~last_r[15:8],
			drv_lo ? rd[7:0] : ~last_r[7:0]};
	end
	assign #T_ACC o_data = raw;
endmodule : sram_model

// [testbench/test_async_sram_1m_x16_byte_lanes.sv]
// Purpose: Self-checking bench for the static memory controller.
// Assumes: Memory model on the pins; inputs change at falling edges.
// Notes:   Reads always follow a write of the same word.
`include "sram_ctrl_map.svh"
module test_async_sram_1m_x16_byte_lanes;
	timeunit 1ns;
	timeprecision 1ps;
	logic        i_clk, i_arst_n, i_req_valid, i_req_write, o_req_ready;
	logic        o_rsp_valid, o_init_done, o_chip_sel_n, o_out_drive_n;
	logic        o_write_strobe_n, o_low_lane_enable_n;
	logic        o_high_lane_enable_n, o_sram_data_oe_n;
	logic [19:0] i_req_addr, o_sram_addr, a;
	logic [15:0] i_req_wdata, o_rsp_rdata, o_sram_data, i_sram_data;
	logic [15:0] mem_q;
	logic [1:0]  i_req_be;
	logic [15:0] shadow [int];
	int          fails, total_checks, seed, n;

	// =================================================================
	// Bus level: controller when enabled, else the memory.
	assign i_sram_data = !o_sram_data_oe_n ? o_sram_data : mem_q;
	sram_ctrl dut_u (.i_clk(i_clk), .i_arst_n(i_arst_n),
		.i_req_valid(i_req_valid), .o_req_ready(o_req_ready),
		.i_req_write(i_req_write), .i_req_addr(i_req_addr),
		.i_req_wdata(i_req_wdata), .i_req_be(i_req_be),
		.o_rsp_valid(o_rsp_valid), .o_rsp_rdata(o_rsp_rdata),
		.o_init_done(o_init_done), .o_sram_addr(o_sram_addr),
		.o_chip_sel_n(o_chip_sel_n), .o_out_drive_n(o_out_drive_n),
		.o_write_strobe_n(o_write_strobe_n),
		.o_low_lane_enable_n(o_low_lane_enable_n),
		.o_high_lane_enable_n(o_high_lane_enable_n),
		.i_sram_data(i_sram_data), .o_sram_data(o_sram_data),
		.o_sram_data_oe_n(o_sram_data_oe_n));
	sram_model #(.T_ACC(30)) mem_u (.i_addr(o_sram_addr),
		.i_cs_n(o_chip_sel_n), .i_oe_n(o_out_drive_n),
		.i_we_n(o_write_strobe_n), .i_lo_n(o_low_lane_enable_n),
		.i_hi_n(o_high_lane_enable_n), .i_bus(i_sram_data), .o_data(mem_q));

	// =================================================================
	// Helpers; byte enable 00 means both lanes.
	function automatic logic [15:0] mask(input logic [1:0] b);
		return {{8{b[1] || b == 2'h0}}, {8{b[0] || b == 2'h0}}};
	endfunction : mask
	task automatic finish_test();
		if (fails == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : finish_test
	task automatic check(string s, logic [15:0] e, logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %s exp %h got %h", s, e, g);
		end
	endtask : check
	// Valid stays up after a write so writes can run back to back.
	task automatic req(logic w, logic [19:0] ad, logic [15:0] d,
		logic [1:0] b);
		int k;
		i_req_valid = 1'b1;
		i_req_write = w;
		i_req_addr = ad;
		i_req_wdata = d;
		i_req_be = b;
		for (k = 0; k < 50 && o_req_ready !== 1'b1; k++) @(negedge i_clk);
		if (o_req_ready !== 1'b1) begin
			fails++;
			finish_test();
		end
		@(negedge i_clk);
	endtask : req
	task automatic wr(logic [19:0] ad, logic [15:0] d, logic [1:0] b);
		logic [15:0] o;
		o = shadow.exists(int'(ad)) ? shadow[int'(ad)] : 16'h0000;
		req(1'b1, ad, d, b);
		shadow[int'(ad)] = (o & ~mask(b)) | (d & mask(b));
	endtask : wr
	task automatic rd(logic [19:0] ad, logic [1:0] b);
		int k;
		req(1'b0, ad, 16'h0000, b);
		i_req_valid = 1'b0;
		for (k = 0; k < 8 && o_rsp_valid !== 1'b1; k++) @(negedge i_clk);
		if (o_rsp_valid !== 1'b1) begin
			fails++;
			finish_test();
		end
		check("rdata", shadow[int'(ad)] & mask(b), o_rsp_rdata);
	endtask : rd
	// Holds reset six cycles, then waits out the power-up time; a wait
	// that never ends or ends too soon counts as a mismatch.
	task automatic wait_init();
		int   k;
		logic ok;
		repeat (6) @(negedge i_clk);
		i_arst_n = 1'b1;
		for (k = 0; k < 3000 && o_init_done !== 1'b1; k++)
			@(negedge i_clk);
		ok = o_init_done === 1'b1 && k >= `SRAM_POWER_CYC
			&& k <= `SRAM_POWER_CYC + 2;
		check("wait", 16'h0001, {15'h0000, ok});
	endtask : wait_init

	// =================================================================
	// Clock and main sequence.
	initial begin
		i_clk = 1'b0;
		forever #20 i_clk = ~i_clk;
	end
	initial begin
		seed = 32'h0a61;
		{i_arst_n, i_req_valid, i_req_write, i_req_be} = 5'h00;
		{i_req_addr, i_req_wdata} = 36'h0;
		{fails, total_checks} = 64'h0;
		wait_init();
		wr(20'h00000, 16'hA5C3, 2'h0);
		wr(20'h00000, 16'h1E77, 2'h2);
		wr(20'hFFFFF, 16'hFFFF, 2'h3);
		wr(20'hFFFFF, 16'h0012, 2'h1);
		for (n = 0; n < 4; n++) rd(20'h00000, n[1:0]);
		for (n = 0; n < 4; n++) rd(20'hFFFFF, n[1:0]);
		// A reset in mid-run must restart the whole power-up wait.
		i_arst_n = 1'b0;
		wait_init();
		rd(20'h00000, 2'h0);
		for (n = 0; n < 40; n++) begin
			a = 20'($random(seed));
			wr(a, 16'($random(seed)), 2'($random(seed)));
			rd(a, 2'($random(seed)));
		end
		finish_test();
	end
endmodule : test_async_sram_1m_x16_byte_lanes
bind sram_ctrl sram_ctrl_monitor chk_u (.i_clk, .i_arst_n, .i_req_valid,
	.i_req_write, .o_req_ready, .o_rsp_valid, .o_chip_sel_n, .o_out_drive_n,
	.o_write_strobe_n, .o_low_lane_enable_n, .o_high_lane_enable_n,
	.o_sram_data_oe_n, .o_sram_data, .o_sram_addr);
